// ---- include/dpf_regs.svh ----
`ifndef DPF_REGS_SVH
`define DPF_REGS_SVH

`define DPF_ADDR_FINE_DIV   12'h023
`define DPF_ADDR_FINE_GAIN  12'h404
`define DPF_ADDR_CRS_EXP    12'h500
`define DPF_ADDR_CRS_LIN    12'h501
`define DPF_ADDR_PDIV       12'h502
`define DPF_ADDR_CTRL       12'h503
`define DPF_ADDR_A0_LO      12'h504
`define DPF_ADDR_A0_HI      12'h505
`define DPF_ADDR_A1         12'h506
`define DPF_ADDR_A2         12'h507
`define DPF_ADDR_B0_LO      12'h508
`define DPF_ADDR_B0_HI      12'h509
`define DPF_ADDR_B1         12'h50A
`define DPF_ADDR_G0_LO      12'h50B
`define DPF_ADDR_G0_HI      12'h50C
`define DPF_ADDR_G1         12'h50D
`define DPF_ADDR_STATUS     12'h50E
`define DPF_ADDR_TW0        12'h510
`define DPF_ADDR_TW5        12'h515
`define DPF_ADDR_SAMP0      12'h516
`define DPF_ADDR_SAMP3      12'h519

`define DPF_RST_FINE_DIV    4'h5
`define DPF_RST_FINE_GAIN   8'hC8
`define DPF_RST_PDIV        5'h05

`define DPF_CLK_MHZ         250
`define DPF_SPAN_US         131
`define DPF_CRS_SHIFT       4'h6
`define DPF_FINE_K          16'h2800
`define DPF_COEF_SHIFT      5'h0F
`define DPF_A_DEN_SHIFT     4'hB
`define DPF_A1_MAX          5'h16
`define DPF_PDIV_MAX        5'h10
`endif

// ---- include/dpf_pkg.sv ----
`default_nettype none
package dpf_pkg;
    typedef enum logic [1:0] {
        M_IDLE,
        M_REF,
        M_FB,
        M_HOLD
    } dpf_meas_t;

    typedef struct packed {
        logic [3:0]  fine_div;
        logic [7:0]  fine_gain;
        logic [2:0]  crs_exp;
        logic [5:0]  crs_lin;
        logic [4:0]  pdiv_exp;
        logic        close_loop;
        logic [11:0] a0;
        logic [4:0]  a1;
        logic [2:0]  a2;
        logic [11:0] b0;
        logic [2:0]  b1;
        logic [11:0] g0;
        logic [2:0]  g1;
    } dpf_cfg_t;

    typedef struct packed {
        logic [47:0] word;
        logic        update;
    } dpf_tune_t;
endpackage
`default_nettype wire

// ---- hw/dpf_edge_sync.sv ----
`default_nettype none
module dpf_edge_sync #(
    parameter int N = 2
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic [N-1:0] pin_in,
    output logic      [N-1:0] rise
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } dpf_sync_st_t;

    dpf_sync_st_t st_r;
    dpf_sync_st_t st_nxt;

    // edge detect looks only at the second and third stages
    assign rise = st_r.s2 & ~st_r.s3;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- hw/dpf_fifo.sv ----
`default_nettype none
module dpf_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 32,
    parameter int PW    = $clog2(DEPTH)
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [PW:0]             cnt;
    } dpf_fifo_st_t;

    dpf_fifo_st_t st_r;
    dpf_fifo_st_t st_nxt;

    assign in_ready  = st_r.cnt != (PW+1)'(DEPTH);
    assign out_valid = st_r.cnt != '0;
    assign out_data  = st_r.mem[st_r.rp];

    always_comb begin
        logic push;
        logic pop;
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + PW'(1);
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + PW'(1);
        end
        case ({push, pop})
            2'b10: st_nxt.cnt = st_r.cnt + (PW+1)'(1);
            2'b01: st_nxt.cnt = st_r.cnt - (PW+1)'(1);
            default: st_nxt.cnt = st_r.cnt;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- hw/dpf_loop_core.sv ----
// Local design decision: the address-and-strobe port.
`include "dpf_regs.svh"
`default_nettype none
module dpf_loop_core #(
    parameter int CLK_MHZ  = `DPF_CLK_MHZ,
    parameter int CW       = 18,
    parameter int SPAN_CYC = `DPF_SPAN_US * CLK_MHZ,
    parameter int FINE_WIN = 1,
    parameter int FRAC     = 22,
    parameter int AW       = 64,
    parameter int FDEPTH   = 32
) (
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               ref_edge_in,
    input  wire logic               fb_edge_in,
    input  wire logic [11:0]        reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    output var dpf_pkg::dpf_tune_t  tune_out
);
    typedef struct packed {
        dpf_pkg::dpf_cfg_t  cfg;
        logic [7:0]         rdata;
        dpf_pkg::dpf_meas_t meas;
        logic [CW-1:0]      mcnt;
        logic [CW:0]        err;
        logic [6:0]         fcnt;
        logic [16:0]        pcnt;
        logic [31:0]        samp;
        logic               samp_v;
        logic [AW-1:0]      v;
        logic [AW-1:0]      s;
        logic [47:0]        tw;
        logic               tw_v;
    } dpf_core_st_t;

    localparam dpf_pkg::dpf_cfg_t CFG_RST = '{
        fine_div:  `DPF_RST_FINE_DIV,
        fine_gain: `DPF_RST_FINE_GAIN,
        pdiv_exp:  `DPF_RST_PDIV,
        default:   '0
    };
    localparam dpf_core_st_t ST_RST = '{cfg: CFG_RST, meas: dpf_pkg::M_IDLE, default: '0};

    localparam logic signed [127:0] S32_MAX = (128'sh1 <<< 31) - 128'sh1;
    localparam logic signed [127:0] S32_MIN = -(128'sh1 <<< 31);
    localparam logic signed [127:0] ACC_MAX = (128'sh1 <<< (AW - 1)) - 128'sh1;
    localparam logic signed [127:0] ACC_MIN = -(128'sh1 <<< (AW - 1));
    localparam logic signed [127:0] TW_MAX  = (128'sh1 <<< 48) - 128'sh1;

    dpf_core_st_t st_r;
    dpf_core_st_t st_nxt;

    logic [1:0]  edge_p;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [31:0] fifo_data;
    logic        fine_tick;
    logic        p_tick;
    logic        pop;
    logic        take;
    logic [3:0]  div_eff;
    logic [4:0]  pexp_eff;

    function automatic logic signed [127:0] clamp(input logic signed [127:0] x,
                                                  input logic signed [127:0] lo,
                                                  input logic signed [127:0] hi);
        if (x > hi) begin
            return hi;
        end else if (x < lo) begin
            return lo;
        end
        return x;
    endfunction

    dpf_edge_sync #(
        .N(2)
    ) u_sync (
        .mclk   (mclk),
        .reset  (reset),
        .pin_in ({fb_edge_in, ref_edge_in}),
        .rise   (edge_p)
    );

    // samples wait here while the filter drains slower than the detector fills
    dpf_fifo #(
        .W     (32),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .reset     (reset),
        .in_valid  (st_r.samp_v),
        .in_data   (st_r.samp),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_ready (p_tick),
        .out_data  (fifo_data)
    );

    // a zero divider would give no sampling rate at all; it acts as one
    assign div_eff   = (st_r.cfg.fine_div == 4'h0) ? 4'h1 : st_r.cfg.fine_div;
    assign pexp_eff  = (st_r.cfg.pdiv_exp > `DPF_PDIV_MAX) ? `DPF_PDIV_MAX : st_r.cfg.pdiv_exp;
    assign fine_tick = st_r.fcnt == 7'h00;
    assign p_tick    = st_r.pcnt == 17'h00000;
    assign pop       = p_tick && fifo_out_valid;
    assign take      = (st_r.meas == dpf_pkg::M_HOLD) && fine_tick && !st_r.samp_v;

    assign reg_rdata = st_r.rdata;
    assign tune_out  = '{word: st_r.tw, update: st_r.tw_v};

    always_comb begin
        logic signed [127:0] ex;
        logic signed [127:0] raw;
        logic signed [127:0] xf;
        logic signed [127:0] vx;
        logic signed [127:0] sx;
        logic signed [127:0] bv;
        logic signed [127:0] gv;
        logic signed [127:0] sn;
        logic signed [127:0] y;
        logic [4:0]          a1c;
        logic [47:0]         twsh;
        logic [31:0]         smsh;
        ex   = '0;
        raw  = '0;
        xf   = '0;
        vx   = '0;
        sx   = '0;
        bv   = '0;
        gv   = '0;
        sn   = '0;
        y    = '0;
        a1c  = '0;
        twsh = '0;
        smsh = '0;

        st_nxt       = st_r;
        st_nxt.rdata = 8'h00;
        st_nxt.tw_v  = 1'b0;

        if (reg_wr) begin
            if (reg_addr == `DPF_ADDR_FINE_DIV) st_nxt.cfg.fine_div = reg_wdata[3:0];
            else if (reg_addr == `DPF_ADDR_FINE_GAIN) st_nxt.cfg.fine_gain = reg_wdata;
            else if (reg_addr == `DPF_ADDR_CRS_EXP) st_nxt.cfg.crs_exp = reg_wdata[2:0];
            else if (reg_addr == `DPF_ADDR_CRS_LIN) st_nxt.cfg.crs_lin = reg_wdata[5:0];
            else if (reg_addr == `DPF_ADDR_PDIV) st_nxt.cfg.pdiv_exp = reg_wdata[4:0];
            else if (reg_addr == `DPF_ADDR_CTRL) st_nxt.cfg.close_loop = reg_wdata[0];
            else if (reg_addr == `DPF_ADDR_A0_LO) st_nxt.cfg.a0[7:0] = reg_wdata;
            else if (reg_addr == `DPF_ADDR_A0_HI) st_nxt.cfg.a0[11:8] = reg_wdata[3:0];
            else if (reg_addr == `DPF_ADDR_A1) st_nxt.cfg.a1 = reg_wdata[4:0];
            else if (reg_addr == `DPF_ADDR_A2) st_nxt.cfg.a2 = reg_wdata[2:0];
            else if (reg_addr == `DPF_ADDR_B0_LO) st_nxt.cfg.b0[7:0] = reg_wdata;
            else if (reg_addr == `DPF_ADDR_B0_HI) st_nxt.cfg.b0[11:8] = reg_wdata[3:0];
            else if (reg_addr == `DPF_ADDR_B1) st_nxt.cfg.b1 = reg_wdata[2:0];
            else if (reg_addr == `DPF_ADDR_G0_LO) st_nxt.cfg.g0[7:0] = reg_wdata;
            else if (reg_addr == `DPF_ADDR_G0_HI) st_nxt.cfg.g0[11:8] = reg_wdata[3:0];
            else if (reg_addr == `DPF_ADDR_G1) st_nxt.cfg.g1 = reg_wdata[2:0];
        end

        if (reg_rd) begin
            if (reg_addr == `DPF_ADDR_FINE_DIV) st_nxt.rdata = {4'h0, st_r.cfg.fine_div};
            else if (reg_addr == `DPF_ADDR_FINE_GAIN) st_nxt.rdata = st_r.cfg.fine_gain;
            else if (reg_addr == `DPF_ADDR_CRS_EXP) st_nxt.rdata = {5'h00, st_r.cfg.crs_exp};
            else if (reg_addr == `DPF_ADDR_CRS_LIN) st_nxt.rdata = {2'h0, st_r.cfg.crs_lin};
            else if (reg_addr == `DPF_ADDR_PDIV) st_nxt.rdata = {3'h0, st_r.cfg.pdiv_exp};
            else if (reg_addr == `DPF_ADDR_CTRL) st_nxt.rdata = {7'h00, st_r.cfg.close_loop};
            else if (reg_addr == `DPF_ADDR_A0_LO) st_nxt.rdata = st_r.cfg.a0[7:0];
            else if (reg_addr == `DPF_ADDR_A0_HI) st_nxt.rdata = {4'h0, st_r.cfg.a0[11:8]};
            else if (reg_addr == `DPF_ADDR_A1) st_nxt.rdata = {3'h0, st_r.cfg.a1};
            else if (reg_addr == `DPF_ADDR_A2) st_nxt.rdata = {5'h00, st_r.cfg.a2};
            else if (reg_addr == `DPF_ADDR_B0_LO) st_nxt.rdata = st_r.cfg.b0[7:0];
            else if (reg_addr == `DPF_ADDR_B0_HI) st_nxt.rdata = {4'h0, st_r.cfg.b0[11:8]};
            else if (reg_addr == `DPF_ADDR_B1) st_nxt.rdata = {5'h00, st_r.cfg.b1};
            else if (reg_addr == `DPF_ADDR_G0_LO) st_nxt.rdata = st_r.cfg.g0[7:0];
            else if (reg_addr == `DPF_ADDR_G0_HI) st_nxt.rdata = {4'h0, st_r.cfg.g0[11:8]};
            else if (reg_addr == `DPF_ADDR_G1) st_nxt.rdata = {5'h00, st_r.cfg.g1};
            else if (reg_addr == `DPF_ADDR_STATUS) begin
                st_nxt.rdata = {4'h0, st_r.meas == dpf_pkg::M_HOLD, st_r.cfg.close_loop,
                                !fifo_in_ready, !fifo_out_valid};
            end else if (reg_addr >= `DPF_ADDR_TW0 && reg_addr <= `DPF_ADDR_TW5) begin
                twsh = st_r.tw >> {reg_addr - `DPF_ADDR_TW0, 3'h0};
                st_nxt.rdata = twsh[7:0];
            end else if (reg_addr >= `DPF_ADDR_SAMP0 && reg_addr <= `DPF_ADDR_SAMP3) begin
                smsh = st_r.samp >> {reg_addr - `DPF_ADDR_SAMP0, 3'h0};
                st_nxt.rdata = smsh[7:0];
            end
        end

        if (st_r.samp_v && fifo_in_ready) begin
            st_nxt.samp_v = 1'b0;
        end

        // edges that arrive while a measurement waits for the fine sampler are not counted
        case (st_r.meas)
            dpf_pkg::M_IDLE: begin
                if (edge_p[0] && edge_p[1]) begin
                    st_nxt.err  = '0;
                    st_nxt.meas = dpf_pkg::M_HOLD;
                end else if (edge_p[0]) begin
                    st_nxt.mcnt = CW'(1);
                    st_nxt.meas = dpf_pkg::M_REF;
                end else if (edge_p[1]) begin
                    st_nxt.mcnt = CW'(1);
                    st_nxt.meas = dpf_pkg::M_FB;
                end
            end
            dpf_pkg::M_REF: begin
                if (edge_p[1]) begin
                    st_nxt.err  = {1'b0, st_r.mcnt};
                    st_nxt.meas = dpf_pkg::M_HOLD;
                end else if (st_r.mcnt < CW'(SPAN_CYC)) begin
                    st_nxt.mcnt = st_r.mcnt + CW'(1);
                end
            end
            dpf_pkg::M_FB: begin
                if (edge_p[0]) begin
                    st_nxt.err  = (CW+1)'(0) - {1'b0, st_r.mcnt};
                    st_nxt.meas = dpf_pkg::M_HOLD;
                end else if (st_r.mcnt < CW'(SPAN_CYC)) begin
                    st_nxt.mcnt = st_r.mcnt + CW'(1);
                end
            end
            dpf_pkg::M_HOLD: begin
                if (take) begin
                    ex = 128'($signed(st_r.err));
                    if (ex <= FINE_WIN && ex >= -FINE_WIN) begin
                        raw = (ex * $signed({112'h0, 8'h00, st_r.cfg.fine_gain})
                               * $signed({112'h0, `DPF_FINE_K})) / CLK_MHZ;
                    end else begin
                        raw = (ex * $signed({122'h0, st_r.cfg.crs_lin}))
                              <<< (st_r.cfg.crs_exp + `DPF_CRS_SHIFT);
                    end
                    st_nxt.samp   = 32'(clamp(raw, S32_MIN, S32_MAX));
                    st_nxt.samp_v = 1'b1;
                    st_nxt.meas   = dpf_pkg::M_IDLE;
                end
            end
            default: st_nxt.meas = dpf_pkg::M_IDLE;
        endcase

        st_nxt.fcnt = fine_tick ? (7'({div_eff, 2'b00}) - 7'h01) : st_r.fcnt - 7'h01;
        st_nxt.pcnt = p_tick ? ((17'h00001 << pexp_eff) - 17'h00001)
                             : st_r.pcnt - 17'h00001;

        if (!st_r.cfg.close_loop) begin
            // an open loop forgets its history so closing it starts clean
            st_nxt.v = '0;
            st_nxt.s = '0;
        end else if (pop) begin
            xf = 128'($signed(fifo_data)) <<< FRAC;
            vx = 128'($signed(st_r.v));
            sx = 128'($signed(st_r.s));
            bv = (vx * $signed({116'h0, st_r.cfg.b0})) >>> (st_r.cfg.b1 + `DPF_COEF_SHIFT);
            gv = (vx * $signed({116'h0, st_r.cfg.g0})) >>> (st_r.cfg.g1 + `DPF_COEF_SHIFT);
            st_nxt.v = AW'(clamp(vx - gv + xf, ACC_MIN, ACC_MAX));
            sn = clamp(sx + xf - bv, ACC_MIN, ACC_MAX);
            st_nxt.s = AW'(sn);
            a1c = (st_r.cfg.a1 > `DPF_A1_MAX) ? `DPF_A1_MAX : st_r.cfg.a1;
            y = ((sn * $signed({116'h0, st_r.cfg.a0})) <<< a1c)
                >>> (st_r.cfg.a2 + `DPF_A_DEN_SHIFT + FRAC);
            st_nxt.tw   = 48'(clamp(y, 128'sh0, TW_MAX));
            st_nxt.tw_v = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_coarse_count: assert property (
        (st_r.meas == dpf_pkg::M_REF && !edge_p[1] && st_r.mcnt < CW'(SPAN_CYC))
        |=> st_r.mcnt == $past(st_r.mcnt) + CW'(1))
        else $error("coarse counter did not advance by one period");

    a_coarse_span: assert property (
        st_r.mcnt <= CW'(SPAN_CYC))
        else $error("coarse counter passed its span");

    a_span_hold: assert property (
        (st_r.meas == dpf_pkg::M_REF && !edge_p[1] && st_r.mcnt == CW'(SPAN_CYC))
        |=> st_r.mcnt == CW'(SPAN_CYC))
        else $error("coarse counter wrapped past its span");

    a_coarse_gain: assert property (
        (take && FINE_WIN < 2 && st_r.err == (CW+1)'(2))
        |=> st_r.samp == (32'({$past(st_r.cfg.crs_lin), 1'b0})
                          << ($past(st_r.cfg.crs_exp) + `DPF_CRS_SHIFT)))
        else $error("coarse sample does not match programmed gain");

    a_fine_rate: assert property (
        (fine_tick && div_eff == 4'h1) |=> !fine_tick [*3] ##1 fine_tick)
        else $error("fine sampler period is not four clocks for divider one");

    a_div_reset: assert property (
        $past(reset) |-> st_r.cfg.fine_div == `DPF_RST_FINE_DIV)
        else $error("fine divider not at reset value after reset");

    a_gain_reset: assert property (
        $past(reset) |-> st_r.cfg.fine_gain == `DPF_RST_FINE_GAIN)
        else $error("fine gain not at reset value after reset");

    a_filter_rate: assert property (
        st_r.tw_v |-> $past(p_tick) && $past(st_r.cfg.close_loop))
        else $error("filter updated outside a P-divider tick");

    a_pdiv_rate: assert property (
        (p_tick && pexp_eff == 5'h02) |=> !p_tick [*3] ##1 p_tick)
        else $error("filter tick period is not four clocks for exponent two");

    a_gamma_decay: assert property (
        (pop && st_r.cfg.close_loop && fifo_data == 32'h0 && $signed(st_r.v) > 0)
        |=> $signed(st_r.v) <= $signed($past(st_r.v)))
        else $error("gamma term did not act as a negative coefficient");

    a_beta_sign: assert property (
        (pop && st_r.cfg.close_loop && fifo_data == 32'h0 && $signed(st_r.v) > 0)
        |=> $signed(st_r.s) <= $signed($past(st_r.s)))
        else $error("beta term did not act as a negative coefficient");

    a_alpha_zero: assert property (
        (pop && st_r.cfg.close_loop && st_r.cfg.a0 == 12'h000) |=> st_r.tw == 48'h0)
        else $error("zero alpha mantissa gave a nonzero tuning word");

    a_open_hold: assert property (
        !st_r.cfg.close_loop |=> st_r.tw == $past(st_r.tw) && !st_r.tw_v)
        else $error("tuning word moved while the loop was open");

    a_integ_sat: assert property (
        (pop && st_r.cfg.close_loop && $signed(fifo_data) > 0 && st_r.v == '0
         && $signed(st_r.s) >= 0) |=> $signed(st_r.s) >= $signed($past(st_r.s)))
        else $error("integrator wrapped instead of saturating");

    c_coarse_take: cover property (take && (st_r.err > (CW+1)'(FINE_WIN)));
    c_fine_take: cover property (take && st_r.err == '0);
    c_fifo_full: cover property (!fifo_in_ready);
    c_tune_update: cover property (st_r.tw_v && st_r.tw != 48'h0);
    c_damped_pop: cover property (pop && st_r.cfg.close_loop && st_r.cfg.g0 != 12'h000);
endmodule
`default_nettype wire

// ---- test/dpf_edge_gen.sv ----
`default_nettype none
module dpf_edge_gen (
    input  wire logic              mclk,
    input  wire logic              go,
    input  wire logic signed [7:0] lag,
    output logic                   ref_pin,
    output logic                   fb_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ref_pin = 1'b0;
        fb_pin = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                // positive lag: reference leads, negative: feedback leads
                if (lag >= 0) ref_pin <= 1'b1;
                if (lag <= 0) fb_pin <= 1'b1;
                repeat ((lag < 0) ? -lag : lag) @(posedge mclk);
                if (lag > 0) fb_pin <= 1'b1;
                if (lag < 0) ref_pin <= 1'b1;
                // short pulses, one pair per request keeps the pin rate low
                repeat (4) @(posedge mclk);
                ref_pin <= 1'b0;
                fb_pin <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic               mclk;
    logic               reset;
    logic               reg_wr;
    logic               reg_rd;
    logic               go;
    logic               hit;
    logic [11:0]        reg_addr;
    logic [7:0]         reg_wdata;
    logic [7:0]         reg_rdata;
    logic [7:0]         rv;
    logic signed [7:0]  lag;
    logic               ref_pin;
    logic               fb_pin;
    dpf_pkg::dpf_tune_t tune_out;
    logic [31:0]        seed;
    logic [63:0]        got;
    longint             acc;
    longint             smp;
    int                 err_total;
    int                 checks_done;
    int                 e;
    int                 l;
    int                 d;
    longint             vm;
    logic [31:0]        exp_q[$];
    localparam int      SPAN = 64;

    dpf_loop_core #(.SPAN_CYC(SPAN)) u_dut (.mclk(mclk), .reset(reset), .ref_edge_in(ref_pin),
        .fb_edge_in(fb_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tune_out(tune_out));
    dpf_edge_gen u_gen (.mclk(mclk), .go(go), .lag(lag), .ref_pin(ref_pin), .fb_pin(fb_pin));

    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("counts: checks=%0d mismatches=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // one edge pair, then a bounded wait for the filter's update pulse
    task automatic pair(input int dd, input int lim);
        lag <= dd[7:0];
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        hit = 1'b0;
        repeat (lim) begin
            @(posedge mclk);
            #1 if (tune_out.update === 1'b1) hit = 1'b1;
        end
    endtask

    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        go = 1'b0;
        lag = 8'h00;
        seed = 32'h98BC;
        err_total = 0;
        checks_done = 0;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rd(12'h023, rv); chk(rv, 8'h05);
        rd(12'h404, rv); chk(rv, 8'hC8);
        rd(12'h7FF, rv); chk(rv, 8'h00);
        chk(tune_out.word, 48'h0);
        $display("test reset values done");
        wr(12'h023, 8'hFF); rd(12'h023, rv); chk(rv, 8'h0F);
        wr(12'h500, 8'hFF); rd(12'h500, rv); chk(rv, 8'h07);
        wr(12'h501, 8'hFF); rd(12'h501, rv); chk(rv, 8'h3F);
        $display("test field widths done");
        // divider 1, P of 4, alpha of exactly one so the word equals the running sum
        wr(12'h023, 8'h01); wr(12'h502, 8'h02); wr(12'h404, 8'h64);
        wr(12'h504, 8'h00); wr(12'h505, 8'h08); wr(12'h503, 8'h01);
        acc = 0;
        for (int i = 0; i < 15; i++) begin
            seed = lfsr(seed);
            // gain 100 at 250 MHz needs a linear factor times two to the exponent of 64
            e = 1 + int'(seed[2:0]) % 6;
            l = 64 >> e;
            d = (i < 4) ? i - 1 : (i == 14) ? 100 : int'(seed[20:16]) % 25 - 12;
            wr(12'h500, 8'(e)); wr(12'h501, 8'(l));
            pair(d, 150);
            chk(hit, 1'b1);
            if (hit !== 1'b1) break;
            smp = (d >= -1 && d <= 1) ? d * 100 * 10240 / 250
                                      : ((d > SPAN) ? SPAN : d) * l * (1 << (e + 6));
            acc += smp;
            exp_q.push_back(smp[31:0]);
            for (int k = 0; k < 4; k++) begin
                rd(12'h516 + 12'(k), rv);
                got[8*k +: 8] = rv;
            end
            chk(got[31:0], exp_q.pop_front());
            chk(tune_out.word, (acc < 0) ? 48'h0 : acc[47:0]);
        end
        $display("test closed loop done");
        got = 64'(tune_out.word);
        wr(12'h503, 8'h00);
        pair(5, 60);
        chk(hit, 1'b0);
        chk(tune_out.word, got[47:0]);
        wr(12'h503, 8'h01);
        pair(4, 60);
        smp = 4 * l * (1 << (e + 6));
        chk(tune_out.word, smp[47:0]);
        $display("test open loop done");
        // beta 1/16 and gamma 1/32 on a zero error: both must pull the state down
        acc = smp <<< 22;
        vm = acc;
        wr(12'h509, 8'h08); wr(12'h50C, 8'h08); wr(12'h50D, 8'h01);
        for (int i = 0; i < 2; i++) begin
            pair(0, 60);
            chk(hit, 1'b1);
            acc -= (vm * 2048) >>> 15;
            vm -= (vm * 2048) >>> 16;
            chk(tune_out.word, 48'(acc >>> 22));
        end
        $display("test damping done");
        results();
    end
endmodule
`default_nettype wire
